// ==== logic/trr_pkg.sv ====
/*
  Package for the translation result register bank: access encodings,
  field positions, fixed field values and shared types.
  Assumes a single core clock and a core that decodes system-register
  instructions into op0/op1/CRn/CRm/op2 with a current privilege level.
*/
package trr_pkg;

  // ==========================================================
  // system-register encodings
  localparam logic [1:0] TRR_FAR_OP0 = 2'h3;
  localparam logic [2:0] TRR_FAR_OP1 = 3'h6;
  localparam logic [3:0] TRR_FAR_CRN = 4'h6;
  localparam logic [3:0] TRR_FAR_CRM = 4'h0;
  localparam logic [2:0] TRR_FAR_OP2 = 3'h5;

  // result register encoding (op0 3, op1 0, CRn 7, CRm 4, op2 0)
  localparam logic [1:0] TRR_PAR_OP0 = 2'h3;
  localparam logic [2:0] TRR_PAR_OP1 = 3'h0;
  localparam logic [3:0] TRR_PAR_CRN = 4'h7;
  localparam logic [3:0] TRR_PAR_CRM = 4'h4;
  localparam logic [2:0] TRR_PAR_OP2 = 3'h0;

  // privilege levels
  localparam logic [1:0] TRR_EL_MONITOR = 2'h3;

  // ==========================================================
  // field positions of the result register
  localparam int TRR_ATTR_LSB   = 56;
  localparam int TRR_OAHI_LSB   = 48;
  localparam int TRR_OA_LSB     = 12;
  localparam int TRR_EXT_BIT    = 11;
  localparam int TRR_IMP10_BIT  = 10;
  localparam int TRR_SPACE_BIT  = 9;
  localparam int TRR_WALK_BIT   = 8;
  localparam int TRR_SH_LSB     = 7;
  localparam int TRR_FST_LSB    = 1;
  localparam int TRR_FAIL_BIT   = 0;

  // shareability encodings
  localparam logic [1:0] TRR_SH_NON   = 2'h0;
  localparam logic [1:0] TRR_SH_RSVD  = 2'h1;
  localparam logic [1:0] TRR_SH_OUTER = 2'h2;
  localparam logic [1:0] TRR_SH_INNER = 2'h3;

  // physical address width default, below 48 masks upper output bits
  localparam int TRR_PA_BITS_DEF = 48;

  // ==========================================================
  // translation regimes reported by the walker
  typedef enum logic [1:0] {
    TRR_REG_NONSEC = 2'b00,
    TRR_REG_SECURE = 2'b01,
    TRR_REG_REALM  = 2'b10,
    TRR_REG_MON    = 2'b11
  } trr_regime_e;

  typedef enum logic [1:0] {
    TRR_ACC_IDLE = 2'b00,
    TRR_ACC_OK   = 2'b01,
    TRR_ACC_UNDEF = 2'b10
  } trr_acc_e;

  function automatic logic trr_is_far(input logic [1:0] o0,
                                      input logic [2:0] o1,
                                      input logic [3:0] cn,
                                      input logic [3:0] cm,
                                      input logic [2:0] o2);
    trr_is_far = (o0 == TRR_FAR_OP0) && (o1 == TRR_FAR_OP1) &&
                 (cn == TRR_FAR_CRN) && (cm == TRR_FAR_CRM) &&
                 (o2 == TRR_FAR_OP2);
  endfunction : trr_is_far

  function automatic logic trr_is_par(input logic [1:0] o0,
                                      input logic [2:0] o1,
                                      input logic [3:0] cn,
                                      input logic [3:0] cm,
                                      input logic [2:0] o2);
    trr_is_par = (o0 == TRR_PAR_OP0) && (o1 == TRR_PAR_OP1) &&
                 (cn == TRR_PAR_CRN) && (cm == TRR_PAR_CRM) &&
                 (o2 == TRR_PAR_OP2);
  endfunction : trr_is_par

endpackage : trr_pkg

// ==== logic/trr_res_if.sv ====
/*
  Interface carrying one formatted translation result from the
  formatter to the register bank.
  Assumes both ends run on the core clock.
*/
`timescale 1ns/100ps
interface trr_res_if;
  logic        valid;
  logic [63:0] value;
  modport src (output valid, output value);
  modport dst (input  valid, input  value);
endinterface : trr_res_if

// ==== logic/trr_format.sv ====
/*
  Combinational formatter: builds the success or fault layout of the
  result register from the walker's report.
  Assumes the walker holds its report stable while done_i is high.
*/
`timescale 1ns/100ps
module trr_format
  import trr_pkg::*;
#(
  parameter int PA_BITS = TRR_PA_BITS_DEF
) (
  input  wire logic        done_i,
  input  wire logic        fault_i,
  input  wire logic [51:12] oa_i,
  input  wire logic        lpa_en_i,
  input  wire logic        rme_en_i,
  input  wire logic [7:0]  attr_i,
  input  wire logic [1:0]  sh_i,
  input  wire logic        dev_or_nc_i,
  input  wire trr_regime_e regime_i,
  input  wire logic        ext_sec_i,
  input  wire logic        space_ns_i,
  input  wire logic        stage2_i,
  input  wire logic        walk_s2_i,
  input  wire logic [5:0]  fst_i,
  input  wire logic [15:0] impl_hi_i,
  trr_res_if.src           res
);

  // ==========================================================
  // output address mask for narrow physical address widths
  logic [51:12] oa_mask;
  always_comb begin
    for (int i = 12; i < 52; i++) begin
      oa_mask[i] = (i < PA_BITS) || (i >= 48);
    end
  end

  logic [63:0] v;
  logic [1:0]  sh;
  always_comb begin
    v  = 64'h0;
    sh = sh_i;
    if (!fault_i) begin
      // device or fully non-cacheable memory forces outer shareable
      if (dev_or_nc_i) begin
        sh = TRR_SH_OUTER;
      end else if (sh_i == TRR_SH_RSVD) begin
        sh = TRR_SH_OUTER;
      end
      // attributes arrive already resolved (effective values)
      v[TRR_ATTR_LSB +: 8] = attr_i;
      v[47:12] = oa_i[47:12] & oa_mask[47:12];
      if (lpa_en_i) begin
        v[51:48] = oa_i[51:48];
      end
      if (!rme_en_i) begin
        v[TRR_EXT_BIT] = 1'b1;
      end else if (regime_i == TRR_REG_MON) begin
        v[TRR_EXT_BIT] = ext_sec_i;
      end
      // unknown cases take the walker's value; it is architecturally free
      v[TRR_SPACE_BIT] = space_ns_i;
      v[TRR_SH_LSB +: 2] = sh;
      v[TRR_FAIL_BIT] = 1'b0;
    end else begin
      v[63:48] = impl_hi_i;
      v[TRR_EXT_BIT] = 1'b1;
      v[TRR_SPACE_BIT] = stage2_i;
      v[TRR_WALK_BIT] = walk_s2_i;
      v[TRR_FST_LSB +: 6] = fst_i;
      v[TRR_FAIL_BIT] = 1'b1;
    end
  end

  assign res.valid = done_i;
  assign res.value = v;

endmodule : trr_format

// ==== logic/trr_sysreg_dec.sv ====
/*
  Access decoder: classifies one system-register instruction as a
  translation result access, a fault address access, or undefined.
  Assumes the core presents the encoding while req_i is high.
*/
`timescale 1ns/100ps
module trr_sysreg_dec
  import trr_pkg::*;
(
  input  wire logic       req_i,
  input  wire logic [1:0] op0_i,
  input  wire logic [2:0] op1_i,
  input  wire logic [3:0] crn_i,
  input  wire logic [3:0] crm_i,
  input  wire logic [2:0] op2_i,
  input  wire logic [1:0] el_i,
  input  wire logic       rme_en_i,
  output logic            hit_par_o,
  output logic            hit_far_o,
  output logic            undef_o
);

  logic far_enc;
  logic par_enc;

  always_comb begin
    far_enc   = trr_is_far(op0_i, op1_i, crn_i, crm_i, op2_i);
    par_enc   = trr_is_par(op0_i, op1_i, crn_i, crm_i, op2_i);
    hit_par_o = req_i && par_enc;
    // below the monitor level, or without the feature, it is undefined
    hit_far_o = req_i && far_enc && rme_en_i &&
                (el_i == TRR_EL_MONITOR);
    undef_o   = req_i && far_enc && !hit_far_o;
  end

endmodule : trr_sysreg_dec

// ==== logic/trr_top.sv ====
/*
  Translation result register bank with monitor fault address register.
  Assumes one system-register request at a time, synchronous to clk_i.
*/
// How it works
// - fault address register decoded at op0 3, op1 6, CRn 6, CRm 0, op2 5.
// - fault address access below monitor level raises undefined instruction.
// - at monitor level with the feature, writes load and reads return all 64 bits.
// - success puts output address bits 47:12 in bits 47:12.
// - bits 51:48 carry upper address with large addresses, else zero.
// - bits 63:56 hold memory attributes of the applied stages.
// - attributes and shareability may be effective, not descriptor values.
// - shareability in bits 8:7, reserved value 01 never returned.
// - device or fully non-cacheable memory reports outer shareable 10.
// - bit 11 is extended security bit with feature, else one.
// - monitor-regime results encode address space in bits 11 and 9.
// - secure regime with level-2 enable: bit 9 picks intermediate space.
// - other secure cases: bit 9 reflects resulting space with table bits.
// - bit 9 unknown for non-secure and realm stage 1 results.
// - bit 0 clear on success, set selects fault layout.
// - fault layout: 63:48 implementation defined, 47:12 zero, 11 one.
// - fault layout bit 9 reports stage 1 or stage 2 abort.
// - software may write any value; no effect on operation.
// - output address bits 47:12 above physical width read as zero.
// - warm reset leaves result fields unknown; no initialisation needed; this bank clears all its registers to zero on reset.
// - fault layout bit 8 flags stage 2 fault during stage 1 walk.
// - fault layout bits 6:1 carry fault status code.
`timescale 1ns/100ps
module trr_top
  import trr_pkg::*;
#(
  parameter int PA_BITS = TRR_PA_BITS_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // system-register instruction port
  input  wire logic        sr_req_i,
  input  wire logic        sr_write_i,
  input  wire logic [1:0]  sr_op0_i,
  input  wire logic [2:0]  sr_op1_i,
  input  wire logic [3:0]  sr_crn_i,
  input  wire logic [3:0]  sr_crm_i,
  input  wire logic [2:0]  sr_op2_i,
  input  wire logic [1:0]  sr_el_i,
  input  wire logic [63:0] sr_wdata_i,
  output logic             sr_ack_o,
  output logic             sr_undef_o,
  output logic [63:0]      sr_rdata_o,
  // feature configuration
  input  wire logic        rme_en_i,
  input  wire logic        lpa_en_i,
  // translation walker report
  input  wire logic        at_done_i,
  input  wire logic        at_fault_i,
  input  wire logic [51:12] at_oa_i,
  input  wire logic [7:0]  at_attr_i,
  input  wire logic [1:0]  at_sh_i,
  input  wire logic        at_dev_nc_i,
  input  wire trr_regime_e at_regime_i,
  input  wire logic        at_ext_sec_i,
  input  wire logic        at_space_ns_i,
  input  wire logic        at_stage2_i,
  input  wire logic        at_walk_s2_i,
  input  wire logic [5:0]  at_fst_i,
  input  wire logic [15:0] at_impl_hi_i,
  // fault address capture from the protection checker, and result register output
  input  wire logic        gpf_load_i,
  input  wire logic [63:0] gpf_addr_i,
  output logic [63:0]      result_o
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [63:0] par;
    logic [63:0] far;
    logic [63:0] rdata;
    logic        ack;
    logic        undef;
    trr_acc_e    acc;
  } trr_state_s;

  trr_state_s st_r;
  trr_state_s st_nxt;

  trr_res_if res ();

  logic hit_par;
  logic hit_far;
  logic undef;

  trr_format #(
    .PA_BITS (PA_BITS)
  ) u_fmt (
    .done_i      (at_done_i),
    .fault_i     (at_fault_i),
    .oa_i        (at_oa_i),
    .lpa_en_i    (lpa_en_i),
    .rme_en_i    (rme_en_i),
    .attr_i      (at_attr_i),
    .sh_i        (at_sh_i),
    .dev_or_nc_i (at_dev_nc_i),
    .regime_i    (at_regime_i),
    .ext_sec_i   (at_ext_sec_i),
    .space_ns_i  (at_space_ns_i),
    .stage2_i    (at_stage2_i),
    .walk_s2_i   (at_walk_s2_i),
    .fst_i       (at_fst_i),
    .impl_hi_i   (at_impl_hi_i),
    .res         (res)
  );

  trr_sysreg_dec u_dec (
    .req_i     (sr_req_i),
    .op0_i     (sr_op0_i),
    .op1_i     (sr_op1_i),
    .crn_i     (sr_crn_i),
    .crm_i     (sr_crm_i),
    .op2_i     (sr_op2_i),
    .el_i      (sr_el_i),
    .rme_en_i  (rme_en_i),
    .hit_par_o (hit_par),
    .hit_far_o (hit_far),
    .undef_o   (undef)
  );

  // ==========================================================
  // next state
  always_comb begin
    st_nxt       = st_r;
    st_nxt.ack   = 1'b0;
    st_nxt.undef = 1'b0;
    st_nxt.acc   = TRR_ACC_IDLE;
    if (sr_req_i) begin
      st_nxt.ack   = 1'b1;
      st_nxt.rdata = 64'h0;
      if (undef) begin
        st_nxt.undef = 1'b1;
        st_nxt.acc   = TRR_ACC_UNDEF;
      end else if (hit_far) begin
        st_nxt.acc = TRR_ACC_OK;
        if (sr_write_i) begin
          st_nxt.far = sr_wdata_i;
        end else begin
          st_nxt.rdata = st_r.far;
        end
      end else if (hit_par) begin
        st_nxt.acc = TRR_ACC_OK;
        if (sr_write_i) begin
          // stored only; nothing else in the core reads it
          st_nxt.par = sr_wdata_i;
        end else begin
          st_nxt.rdata = st_r.par;
        end
      end
    end
    if (gpf_load_i && !(hit_far && sr_write_i)) begin
      st_nxt.far = gpf_addr_i;
    end
    // a completing translation wins over a software write in the same cycle
    if (res.valid) begin
      st_nxt.par = res.value;
    end
  end

  // ==========================================================
  // register; data fields are cleared for determinism though free
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign sr_ack_o   = st_r.ack;
  assign sr_undef_o = st_r.undef;
  assign sr_rdata_o = st_r.rdata;
  assign result_o   = st_r.par;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_far_undef_low: assert property (
    sr_req_i && ce_i && trr_is_far(sr_op0_i, sr_op1_i, sr_crn_i,
      sr_crm_i, sr_op2_i) && sr_el_i != TRR_EL_MONITOR
    |=> sr_undef_o && sr_ack_o)
    else $error("low level access not undefined");

  a_far_round_trip: assert property (
    ce_i && sr_req_i && hit_far && sr_write_i && !res.valid
    ##1 ce_i && sr_req_i && hit_far && !sr_write_i
    |=> sr_rdata_o == $past(sr_wdata_i, 2))
    else $error("fault address write not read back");

  a_sh_not_rsvd: assert property (
    ce_i && at_done_i && !at_fault_i
    |=> result_o[8:7] != TRR_SH_RSVD)
    else $error("reserved shareability returned");

  a_sh_dev_outer: assert property (
    ce_i && at_done_i && !at_fault_i && at_dev_nc_i
    |=> result_o[8:7] == TRR_SH_OUTER)
    else $error("device memory not outer shareable");

  a_ok_layout: assert property (
    ce_i && at_done_i && !at_fault_i
    |=> result_o[0] == 1'b0 && result_o[63:56] == $past(at_attr_i)
        && result_o[6:1] == 6'h0)
    else $error("success layout wrong");

  a_ok_hi_zero: assert property (
    ce_i && at_done_i && !at_fault_i && !lpa_en_i
    |=> result_o[51:48] == 4'h0)
    else $error("upper address bits not zero");

  a_fault_layout: assert property (
    ce_i && at_done_i && at_fault_i
    |=> result_o[0] && result_o[47:12] == 36'h0 && result_o[11]
        && !result_o[10] && result_o[9] == $past(at_stage2_i))
    else $error("fault layout wrong");

  a_fault_fst: assert property (
    ce_i && at_done_i && at_fault_i
    |=> result_o[6:1] == $past(at_fst_i)
        && result_o[8] == $past(at_walk_s2_i))
    else $error("fault status not captured");

  a_ext_no_rme: assert property (
    ce_i && at_done_i && !at_fault_i && !rme_en_i
    |=> result_o[11])
    else $error("bit 11 not one without feature");

  a_par_write: assert property (
    ce_i && sr_req_i && hit_par && sr_write_i && !res.valid
    |=> result_o == $past(sr_wdata_i))
    else $error("result register write lost");

  c_ok_xlat:   cover property (ce_i && at_done_i && !at_fault_i);
  c_fault:     cover property (ce_i && at_done_i && at_fault_i);
  c_undef:     cover property (sr_undef_o);
  c_far_read:  cover property (ce_i && hit_far && !sr_write_i);

endmodule : trr_top

// ==== tb/trr_core_model.sv ====
/*
  Core-side model: issues one system-register instruction at a time on
  the bank's request port and collects the registered answer.
  Assumes one core clock; inputs driven on its falling edge.
*/
`timescale 1ns/100ps
module trr_core_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic        undef_i,
  input  wire logic [63:0] rdata_i,
  output logic             req_o,
  output logic             write_o,
  output logic [15:0]      enc_o,
  output logic [1:0]       el_o,
  output logic [63:0]      wdata_o
);
  // ==========================================================
  // idle state
  initial begin
    req_o   = 1'h0;
    write_o = 1'h0;
    enc_o   = 16'h0000;
    el_o    = 2'h0;
    wdata_o = 64'h0;
  end

  // ==========================================================
  // one instruction; ok stays low if no answer comes within 4 cycles
  task automatic access(input  logic        wr,
                        input  logic [15:0] enc,
                        input  logic [1:0]  el,
                        input  logic [63:0] wd,
                        output logic [63:0] rd,
                        output logic        und,
                        output logic        ok);
    int n;
    ok  = 1'h0;
    rd  = 64'h0;
    und = 1'h0;
    @(negedge clk_i);
    req_o   = 1'h1;
    write_o = wr;
    enc_o   = enc;
    el_o    = el;
    wdata_o = wd;
    @(negedge clk_i);
    req_o   = 1'h0;
    // released lines must not keep looking valid
    enc_o   = ~enc;
    wdata_o = ~wd;
    for (n = 0; n < 4 && !ok; n++) begin
      if (ack_i === 1'h1) begin
        ok  = 1'h1;
        rd  = rdata_i;
        und = undef_i;
      end else begin
        @(negedge clk_i);
      end
    end
  endtask : access
endmodule : trr_core_model

// ==== tb/tb_top.sv ====
/*
  Self-checking bench for the translation result register bank.
  Assumes the design package and interface are compiled first.
*/
`timescale 1ns/100ps
module tb_top
  import trr_pkg::*;
;
  localparam int PAB = 40;
  localparam logic [15:0] E_FAR = {TRR_FAR_OP0, TRR_FAR_OP1, TRR_FAR_CRN,
                                   TRR_FAR_CRM, TRR_FAR_OP2};
  localparam logic [15:0] E_PAR = {TRR_PAR_OP0, TRR_PAR_OP1, TRR_PAR_CRN,
                                   TRR_PAR_CRM, TRR_PAR_OP2};
  localparam logic [1:0]  MON   = TRR_EL_MONITOR;
  localparam logic [63:0] ALL   = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] FMSK  = 64'h0000_FFFF_FFFF_FFFF;

  logic clk_i = 1'h0, rst_i = 1'h1, rme = 1'h1, lpa = 1'h0;
  logic req, wr, ack, und_o, done = 1'h0, flt = 1'h0, dn = 1'h0;
  logic ex = 1'h0, ns = 1'h0, s2 = 1'h0, pw = 1'h0, gl = 1'h0;
  logic [15:0] enc;
  logic [1:0]  el, sh = 2'h0;
  logic [63:0] wd, rdo, res, ga = 64'h0, rd;
  logic [51:12] oa = 40'h0;
  logic [7:0]  at = 8'h0;
  logic [5:0]  fs = 6'h00;
  logic [15:0] ih = 16'h0000;
  trr_regime_e rg = TRR_REG_MON;
  logic        und, ok;
  int fail_count = 0, checks_done = 0;

  always #20 clk_i = ~clk_i;

  trr_core_model CORE (.clk_i(clk_i), .ack_i(ack), .undef_i(und_o),
    .rdata_i(rdo), .req_o(req), .write_o(wr), .enc_o(enc), .el_o(el),
    .wdata_o(wd));

  trr_top #(.PA_BITS(PAB)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1),
    .sr_req_i(req), .sr_write_i(wr), .sr_op0_i(enc[15:14]),
    .sr_op1_i(enc[13:11]), .sr_crn_i(enc[10:7]), .sr_crm_i(enc[6:3]),
    .sr_op2_i(enc[2:0]), .sr_el_i(el), .sr_wdata_i(wd), .sr_ack_o(ack),
    .sr_undef_o(und_o), .sr_rdata_o(rdo), .rme_en_i(rme), .lpa_en_i(lpa),
    .at_done_i(done), .at_fault_i(flt), .at_oa_i(oa), .at_attr_i(at),
    .at_sh_i(sh), .at_dev_nc_i(dn), .at_regime_i(rg), .at_ext_sec_i(ex),
    .at_space_ns_i(ns), .at_stage2_i(s2), .at_walk_s2_i(pw),
    .at_fst_i(fs), .at_impl_hi_i(ih), .gpf_load_i(gl), .gpf_addr_i(ga),
    .result_o(res));

  // ==========================================================
  // reporting
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk64(input logic [63:0] got, exp, msk);
    checks_done++;
    if ((got & msk) !== (exp & msk)) begin
      fail_count++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk64

  task automatic chk1(input logic got, exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1

  // ==========================================================
  // bus and walker drivers
  task automatic sr(input logic w, input logic [15:0] e,
                    input logic [1:0] l, input logic [63:0] d);
    CORE.access(w, e, l, d, rd, und, ok);
    if (!ok) begin
      fail_count++;
      $display("[FAIL] %0t no acknowledge", $time);
      summarize();
    end
  endtask : sr

  task automatic walk(input logic f, input logic [51:12] a,
                      input logic [7:0] t, input logic [1:0] s,
                      input logic d, input trr_regime_e r,
                      input logic x, n, st2, wk, input logic [5:0] c);
    @(negedge clk_i);
    {done, flt, oa, at, sh, dn, rg, ex, ns, s2, pw, fs} =
      {1'h1, f, a, t, s, d, r, x, n, st2, wk, c};
    ih = 16'hBEEF;
    @(negedge clk_i);
    done = 1'h0;
    oa   = ~a;
  endtask : walk

  // success layout as the rules build it for the current feature inputs
  function automatic logic [63:0] okv(input logic [51:12] a,
      input logic [7:0] t, input logic [1:0] s, input logic d, x, n);
    logic [63:0] v;
    v = 64'h0;
    v[63:56] = t;
    if (lpa) v[51:48] = a[51:48];
    v[47:12] = a[47:12];
    v = v & ~(64'h0000_FFFF_FFFF_F000 & ~((64'h1 << PAB) - 64'h1));
    v[11] = rme ? x : 1'h1;
    v[9] = n;
    v[8:7] = (d || s == TRR_SH_RSVD) ? TRR_SH_OUTER : s;
    return v;
  endfunction : okv

  function automatic logic [63:0] fv(input logic st2, wk,
                                     input logic [5:0] c);
    return {16'h0000, 36'h0, 1'h1, 1'h0, st2, wk, 1'h0, c, 1'h1};
  endfunction : fv

  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(negedge clk_i);
    rst_i = 1'h0;
    sr(1'h1, E_FAR, MON, 64'hA5A5_0F0F_1234_5678);
    chk1(und, 1'h0);
    sr(1'h0, E_FAR, MON, 64'h0);
    chk64(rd, 64'hA5A5_0F0F_1234_5678, ALL);
    for (int l = 0; l < 3; l++) begin
      sr(1'h1, E_FAR, 2'(l), 64'h0);
      chk1(und, 1'h1);
      sr(1'h0, E_FAR, 2'(l), 64'h0);
      chk1(und, 1'h1);
      chk64(rd, 64'h0, ALL);
    end
    sr(1'h0, E_FAR, MON, 64'h0);
    chk64(rd, 64'hA5A5_0F0F_1234_5678, ALL);
    rme = 1'h0;
    sr(1'h0, E_FAR, MON, 64'h0);
    chk1(und, 1'h1);
    rme = 1'h1;
    sr(1'h0, E_FAR ^ 16'h0001, MON, 64'h0);
    chk1(und, 1'h0);
    chk64(rd, 64'h0, ALL);
    @(negedge clk_i);
    {gl, ga} = {1'h1, 64'h8000_0123_4567_8000};
    @(negedge clk_i);
    {gl, ga} = {1'h0, 64'h7FFF_FEDC_BA98_7FFF};
    sr(1'h0, E_FAR, MON, 64'h0);
    chk64(rd, 64'h8000_0123_4567_8000, ALL);

    walk(1'h0, 40'hA_BCDE_F123_4, 8'hFF, 2'h3, 1'h0, TRR_REG_MON,
         1'h1, 1'h0, 1'h0, 1'h0, 6'h00);
    chk64(res, okv(40'hA_BCDE_F123_4, 8'hFF, 2'h3, 1'h0, 1'h1, 1'h0),
          ALL);
    sr(1'h0, E_PAR, MON, 64'h0);
    chk64(rd, okv(40'hA_BCDE_F123_4, 8'hFF, 2'h3, 1'h0, 1'h1, 1'h0),
          ALL);
    lpa = 1'h1;
    walk(1'h0, 40'h5_0000_0FFF_F, 8'h44, 2'h1, 1'h0, TRR_REG_MON,
         1'h0, 1'h1, 1'h0, 1'h0, 6'h00);
    chk64(res, okv(40'h5_0000_0FFF_F, 8'h44, 2'h1, 1'h0, 1'h0, 1'h1),
          ALL);
    lpa = 1'h0;
    rme = 1'h0;
    walk(1'h0, 40'h0_0012_3456_7, 8'h04, 2'h0, 1'h1, TRR_REG_SECURE,
         1'h0, 1'h1, 1'h0, 1'h0, 6'h00);
    chk64(res, okv(40'h0_0012_3456_7, 8'h04, 2'h0, 1'h1, 1'h0, 1'h1),
          ALL);
    rme = 1'h1;
    walk(1'h1, 40'hF_FFFF_FFFF_F, 8'hFF, 2'h3, 1'h1, TRR_REG_NONSEC,
         1'h0, 1'h0, 1'h1, 1'h1, 6'h25);
    chk64(res, fv(1'h1, 1'h1, 6'h25), FMSK);
    walk(1'h1, 40'h0_0000_0000_1, 8'h00, 2'h0, 1'h0, TRR_REG_SECURE,
         1'h1, 1'h1, 1'h0, 1'h0, 6'h07);
    chk64(res, fv(1'h0, 1'h0, 6'h07), FMSK);

    sr(1'h1, E_PAR, MON, 64'h0123_4567_89AB_CDEF);
    chk64(res, 64'h0123_4567_89AB_CDEF, ALL);
    sr(1'h0, E_PAR, MON, 64'h0);
    chk64(rd, 64'h0123_4567_89AB_CDEF, ALL);
    // a write colliding with completion must lose to the translation
    fork
      sr(1'h1, E_PAR, MON, 64'hFFFF_0000_FFFF_0000);
      walk(1'h0, 40'h0_00AB_CDEF_0, 8'h88, 2'h2, 1'h0, TRR_REG_MON,
           1'h0, 1'h0, 1'h0, 1'h0, 6'h00);
    join
    chk64(res, okv(40'h0_00AB_CDEF_0, 8'h88, 2'h2, 1'h0, 1'h0, 1'h0),
          ALL);
    // mid-run reset: this design clears its registers although free
    @(negedge clk_i);
    rst_i = 1'h1;
    @(negedge clk_i);
    rst_i = 1'h0;
    chk64(res, 64'h0, ALL);
    sr(1'h0, E_FAR, MON, 64'h0);
    chk64(rd, 64'h0, ALL);
    summarize();
  end
endmodule : tb_top
